// *** hw/pch_config_upper.v ***
// Upper configuration header bank with configuration access port
`include "pch_consts.vh"

module pch_config_upper #(
    parameter [23:0] FUNC_CLASS = `PCH_CLASS_DEF, // Class field value
    parameter [15:0] card_maker_param = 16'h_1234, // Arbitrary value
    parameter [15:0] subsystem_param = 16'h_5678 // Arbitrary value
) (
    input wire clk, // Bus clock
    input wire rst, // Synchronous reset, high
    input wire cfg_req, // Configuration request strobe
    input wire cfg_idsel, // Device selected for config
    input wire [3:0] cfg_cmd, // Command code from address phase
    input wire [7:0] cfg_addr, // Byte address in config space
    input wire [3:0] cfg_be_n, // Byte enables, active low
    input wire [31:0] cfg_wdata, // Write data
    output reg cfg_ack, // Request done, one cycle
    output reg [31:0] cfg_rdata, // Read data, held
    output reg cfg_miss, // Selected but other command
    input wire mstr_start, // Master transaction begins
    input wire mstr_active, // Master owns the bus
    output wire [7:0] hold_count, // Remaining hold cycles
    output wire hold_expired, // Hold time used up
    output wire [7:0] hold_setting, // Programmed hold value
    output wire [11:0] memory_window_field, // Memory base bits 31:20
    output wire [11:0] port_window_field, // Port base bits 31:20
    output wire [7:0] irq_routing_line // Interrupt routing value
);

    // Full byte offsets, kept at their own width before slicing
    localparam [7:0] OFS_CLASS = `PCH_OFS_CLASS;
    localparam [7:0] OFS_HOLD = `PCH_OFS_HOLD;
    localparam [7:0] OFS_LAYOUT = `PCH_OFS_LAYOUT;
    localparam [7:0] OFS_MEMWIN = `PCH_OFS_MEMWIN;
    localparam [7:0] OFS_IOWIN = `PCH_OFS_IOWIN;
    localparam [7:0] OFS_MAKER = `PCH_OFS_MAKER;
    localparam [7:0] OFS_IRQLINE = `PCH_OFS_IRQLINE;
    localparam [7:0] OFS_IRQPIN = `PCH_OFS_IRQPIN;
    localparam [7:0] OFS_BURST = `PCH_OFS_BURST;
    localparam [7:0] HOLD_RST = `PCH_HOLD_RST;

    // Dword indices of the mapped words
    localparam [5:0] DW_CLASS = OFS_CLASS[7:2];
    localparam [5:0] DW_HOLD = OFS_HOLD[7:2];
    localparam [5:0] DW_MEMWIN = OFS_MEMWIN[7:2];
    localparam [5:0] DW_IOWIN = OFS_IOWIN[7:2];
    localparam [5:0] DW_MAKER = OFS_MAKER[7:2];
    localparam [5:0] DW_IRQ = OFS_IRQLINE[7:2];

    // Byte lanes of the byte-wide fields
    localparam [1:0] LN_HOLD = OFS_HOLD[1:0];
    localparam [1:0] LN_LAYOUT = OFS_LAYOUT[1:0];
    localparam [1:0] LN_IRQLINE = OFS_IRQLINE[1:0];
    localparam [1:0] LN_IRQPIN = OFS_IRQPIN[1:0];
    localparam [1:0] LN_BURST = OFS_BURST[1:0];

    // Writable state
    reg [4:0] hold_hi;
    reg [11:0] mem_base;
    reg [11:0] io_base;
    reg [7:0] irq_line;

    // Decode results
    wire [5:0] dword;
    wire rd_take;
    wire wr_take;
    wire [3:0] lane_we;
    reg [31:0] next_rdata;

    assign dword = cfg_addr[7:2];

    // Only selected config commands are taken
    assign rd_take = cfg_req && cfg_idsel && (cfg_cmd == `PCH_CMD_CFG_RD);
    assign wr_take = cfg_req && cfg_idsel && (cfg_cmd == `PCH_CMD_CFG_WR);

    // Per-lane write enables from active-low byte enables
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign lane_we[gi] = wr_take && !cfg_be_n[gi];
        end
    endgenerate

    // Hold timer upper bits, low three bits stay zero
    always @(posedge clk) begin
        if (rst) begin
            hold_hi <= HOLD_RST[7:`PCH_HOLD_LSB];
        end else if (lane_we[LN_HOLD] && (dword == DW_HOLD)) begin
            hold_hi <= cfg_wdata[15:11];
        end
    end

    // Memory window base, split over lanes two and three
    always @(posedge clk) begin
        if (rst) begin
            mem_base <= `PCH_WIN_RST;
        end else if (dword == DW_MEMWIN) begin
            if (lane_we[2]) begin
                mem_base[3:0] <= cfg_wdata[23:20];
            end
            if (lane_we[3]) begin
                mem_base[11:4] <= cfg_wdata[31:24];
            end
        end
    end

    // Port window base, split over lanes two and three
    always @(posedge clk) begin
        if (rst) begin
            io_base <= `PCH_WIN_RST;
        end else if (dword == DW_IOWIN) begin
            if (lane_we[2]) begin
                io_base[3:0] <= cfg_wdata[23:20];
            end
            if (lane_we[3]) begin
                io_base[11:4] <= cfg_wdata[31:24];
            end
        end
    end

    // Interrupt routing line, software sets it at power-up
    always @(posedge clk) begin
        if (rst) begin
            irq_line <= `PCH_IRQLINE_RST;
        end else if (lane_we[LN_IRQLINE] && (dword == DW_IRQ)) begin
            irq_line <= cfg_wdata[7:0];
        end
    end

    // Read word assembly; unmapped words and unused bits give zero
    always @* begin
        next_rdata = 32'h_0000_0000;
        case (dword)
            DW_CLASS: begin
                next_rdata[31:8] = FUNC_CLASS;
            end
            DW_HOLD: begin
                next_rdata[LN_HOLD*8 +: 8] = {hold_hi, 3'b000};
                next_rdata[LN_LAYOUT*8 +: 8] = `PCH_LAYOUT_VAL;
            end
            DW_MEMWIN: begin
                next_rdata[31:`PCH_WIN_LSB] = mem_base;
                next_rdata[3:0] = 4'h_0;
            end
            DW_IOWIN: begin
                next_rdata[31:`PCH_WIN_LSB] = io_base;
                next_rdata[1:0] = `PCH_IOWIN_FLAG;
            end
            DW_MAKER: begin
                next_rdata[15:0] = card_maker_param;
                next_rdata[31:16] = subsystem_param;
            end
            DW_IRQ: begin
                next_rdata[LN_IRQLINE*8 +: 8] = irq_line;
                next_rdata[LN_IRQPIN*8 +: 8] = `PCH_IRQPIN_VAL;
                next_rdata[LN_BURST*8 +: 8] = `PCH_BURST_VAL;
            end
            default: begin
                next_rdata = 32'h_0000_0000;
            end
        endcase
    end

    // Answer one cycle after the request; read data holds until next read
    always @(posedge clk) begin
        if (rst) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h_0000_0000;
            cfg_miss <= 1'b0;
        end else begin
            cfg_ack <= rd_take || wr_take;
            cfg_miss <= cfg_req && cfg_idsel && !rd_take && !wr_take;
            if (rd_take) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // Hold timer counting during master ownership
    pch_hold_timer #(
        .WIDTH(8)
    ) u_hold (
        .clk(clk),
        .rst(rst),
        .start(mstr_start),
        .active(mstr_active),
        .init_value({hold_hi, 3'b000}),
        .count(hold_count),
        .expired(hold_expired)
    );

    // Fields for the address decode and master logic
    assign hold_setting = {hold_hi, 3'b000};
    assign memory_window_field = mem_base;
    assign port_window_field = io_base;
    assign irq_routing_line = irq_line;

endmodule // pch_config_upper

// *** hw/pch_consts.vh ***
// Constants for the upper configuration header bank
`ifndef PCH_CONSTS_VH
`define PCH_CONSTS_VH

// Configuration command codes
`define PCH_CMD_CFG_RD 4'h_a
`define PCH_CMD_CFG_WR 4'h_b

// Byte offsets in configuration space
`define PCH_OFS_CLASS 8'h_09
`define PCH_OFS_HOLD 8'h_0d
`define PCH_OFS_LAYOUT 8'h_0e
`define PCH_OFS_MEMWIN 8'h_10
`define PCH_OFS_IOWIN 8'h_14
`define PCH_OFS_MAKER 8'h_2c
`define PCH_OFS_SUBSYS 8'h_2e
`define PCH_OFS_IRQLINE 8'h_3c
`define PCH_OFS_IRQPIN 8'h_3d
`define PCH_OFS_BURST 8'h_3e

// Reset and fixed values
`define PCH_CLASS_DEF 24'h_ff_0000
`define PCH_HOLD_RST 8'h_00
`define PCH_LAYOUT_VAL 8'h_00
`define PCH_WIN_RST 12'h_000
`define PCH_IRQLINE_RST 8'h_ff
`define PCH_IRQPIN_VAL 8'h_01
`define PCH_BURST_VAL 8'h_10
`define PCH_IOWIN_FLAG 2'h_1

// Field positions
`define PCH_WIN_LSB 20
`define PCH_HOLD_LSB 3

`endif

// *** hw/pch_hold_timer.v ***
// Bus hold timer count used while the device masters the bus
`include "pch_consts.vh"

module pch_hold_timer #(
    parameter WIDTH = 8
) (
    input wire clk, // Bus clock
    input wire rst, // Synchronous reset, high
    input wire start, // Master transaction begins
    input wire active, // Master owns the bus
    input wire [WIDTH-1:0] init_value, // Programmed hold time
    output reg [WIDTH-1:0] count, // Remaining cycles
    output wire expired // Hold time used up
);

    // Load on start, then count down each edge while mastering, holding at zero
    always @(posedge clk) begin
        if (rst) begin
            count <= `PCH_HOLD_RST;
        end else if (start) begin
            count <= init_value;
        end else if (active && (count != {WIDTH{1'b0}})) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Ownership must end once the count reaches zero
    assign expired = active && (count == {WIDTH{1'b0}});

endmodule // pch_hold_timer

// *** tb/pch_config_upper_props.sv ***
// Timing checks on the configuration port and hold timer
module pch_config_upper_props (
    input wire clk, // Clock
    input wire rst, // Reset
    input wire cfg_req, // Strobe
    input wire cfg_idsel, // Select
    input wire [3:0] cfg_cmd, // Command
    input wire [7:0] cfg_addr, // Address
    input wire cfg_ack, // Done
    input wire [31:0] cfg_rdata, // Read data
    input wire cfg_miss, // Refused
    input wire mstr_start, // Load
    input wire mstr_active, // Owning
    input wire [7:0] hold_count, // Count
    input wire hold_expired, // Zero
    input wire [7:0] hold_setting // Setting
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Requests that the port takes
    wire take = cfg_req && cfg_idsel && (cfg_cmd == 4'h_a || cfg_cmd == 4'h_b);
    sequence rd_s(logic [5:0] a);
        cfg_req && cfg_idsel && cfg_cmd == 4'h_a && cfg_addr[7:2] == a;
    endsequence
    take_acked_a: assert property (take |=> cfg_ack) else $error("no ack");
    idle_no_ack_a: assert property (!take |=> !cfg_ack) else $error("stray ack");
    other_miss_a: assert property (cfg_req && cfg_idsel && !take |=> cfg_miss) else $error("no miss");
    hold_low_a: assert property (hold_setting[2:0] == 3'h_0) else $error("low bits set");
    hold_load_a: assert property (mstr_start |=> hold_count == $past(hold_setting)) else $error("no load");
    hold_step_a: assert property (mstr_active && !mstr_start && hold_count != 8'h_00
        |=> hold_count == $past(hold_count) - 8'h_01) else $error("no step");
    expire_flag_a: assert property (hold_expired == (mstr_active && hold_count == 8'h_00)) else $error("flag");
    pin_grant_a: assert property (rd_s(6'h_0f) |=> cfg_rdata[31:8] == 24'h_00_1001) else $error("pin");
endmodule // pch_config_upper_props

bind pch_config_upper pch_config_upper_props i_props (.*);

// *** tb/pch_host_model.sv ***
// Host side issuing configuration requests
module pch_host_model (
    input wire clk, // Clock
    output logic cfg_req, // Strobe
    output logic cfg_idsel, // Select
    output logic [3:0] cfg_cmd, // Command
    output logic [7:0] cfg_addr, // Address
    output logic [3:0] cfg_be_n, // Lanes
    output logic [31:0] cfg_wdata // Data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cfg_req, cfg_idsel, cfg_cmd, cfg_addr, cfg_be_n, cfg_wdata} = '0;
    // One strobe, then data scrambled so a stale word is never seen
    task automatic send(input logic s, input logic [3:0] c, input logic [7:0] a, input logic [3:0] b,
                        input logic [31:0] d);
        @(posedge clk);
        #1;
        {cfg_req, cfg_idsel, cfg_cmd, cfg_addr, cfg_be_n, cfg_wdata} = {1'b1, s, c, a, b, d};
        @(posedge clk);
        #1;
        cfg_req = 1'b0;
        cfg_wdata = ~cfg_wdata;
    endtask
endmodule // pch_host_model

// *** tb/test_pch_config_upper.sv ***
// Self-checking bench for the upper configuration header bank
module test_pch_config_upper;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mstr_start = 1'b0;
    logic mstr_active = 1'b0;
    wire cfg_req, cfg_idsel, cfg_ack, cfg_miss, hold_expired;
    wire [3:0] cfg_cmd, cfg_be_n;
    wire [7:0] cfg_addr, hold_count, hold_setting, irq_routing_line;
    wire [31:0] cfg_wdata, cfg_rdata;
    wire [11:0] memory_window_field, port_window_field;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [31:0] w;
    logic [7:0] hs;
    logic [7:0] adr[7] = '{8'h_08, 8'h_0c, 8'h_10, 8'h_14, 8'h_2c, 8'h_3c, 8'h_38};
    logic [31:0] rv[7] = '{32'h_ff00_0000, 0, 0, 32'h_0000_0001, 32'h_5678_1234, 32'h_0010_01ff, 0};
    int n_errors = 0;
    int tests_run = 0;
    int n;
    pch_host_model i_host (.*);
    pch_config_upper i_dut (.*);
    initial forever #20 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Note the answer, then issue a selected request
    task automatic acc(input logic [3:0] c, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        i_host.send(1'b1, c, a, b, d);
    endtask
    // Oldest note popped on every ack, checked against read data when marked
    always @(posedge clk) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) check("ack", 1, 0);
            else note = exp_q.pop_front();
            if (note[32]) check("rdata", cfg_rdata, note[31:0]);
            note = '0;
        end
    end
    initial begin
        w = $urandom(70);
        w = $urandom;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        // Reset values, then every word written with random data
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 7; i++) acc(4'h_a, adr[i], 4'h_f, 0, {1'b1, rv[i]});
            for (int i = 0; i < 7; i++) acc(4'h_b, adr[i], 4'h_0, w, 0);
            rv[1] = {16'h_0000, w[15:11], 11'h_000};
            rv[2] = {w[31:20], 20'h_0_0000};
            rv[3] = {w[31:20], 20'h_0_0001};
            rv[5] = {24'h_00_1001, w[7:0]};
        end
        check("mem", {20'h0, memory_window_field}, {20'h0, w[31:20]});
        check("port", {20'h0, port_window_field}, {20'h0, w[31:20]});
        // Lane two only, then ignored and refused requests
        acc(4'h_b, 8'h_10, 4'h_b, 0, 0);
        acc(4'h_a, 8'h_10, 4'h_0, 0, {1'b1, w[31:24], 24'h_00_0000});
        i_host.send(1'b0, 4'h_b, 8'h_3c, 4'h_0, ~w);
        i_host.send(1'b1, 4'h_6, 8'h_3c, 4'h_0, ~w);
        check("miss", {31'h0, cfg_miss}, 32'h_0000_0001);
        check("irq", {24'h0, irq_routing_line}, {24'h0, w[7:0]});
        // Hold timer load and countdown while mastering
        hs = {w[15:12], 4'h_8};
        acc(4'h_b, 8'h_0c, 4'h_d, {16'h_0000, w[15:12], 12'h_f00}, 0);
        check("hold", {24'h0, hold_setting}, {24'h0, hs});
        @(posedge clk);
        #1;
        mstr_start = 1'b1;
        @(posedge clk);
        #1;
        {mstr_start, mstr_active, n} = {2'b01, 32'd0};
        while (hold_expired !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("count", n, {24'h0, hs});
        // Second reset mid-run restores defaults
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        acc(4'h_a, 8'h_3c, 4'h_0, 0, {1'b1, 32'h_0010_01ff});
        acc(4'h_a, 8'h_0c, 4'h_0, 0, {1'b1, 32'h_0000_0000});
        for (n = 0; exp_q.size() != 0 && n < 10; n++) @(posedge clk);
        if (exp_q.size() != 0) check("drain", 1, 0);
        end_of_test();
    end
endmodule // test_pch_config_upper
